// ### verilog/tpd_pwm_top.sv
// Pulse-width unit on an 8-bit period timer, with its registers on AHB-Lite.
// Assumes a single clk_sys domain, a quiet bus while ce is low, and word accesses.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Duty is ten bits: high register gives top eight, control bits 5:4 give two.
// - Pulse high time equals duty times oscillator period times prescale factor.
// - Duty writes accepted anytime; copied to shadow only at period match.
// - In pulse-width mode software writes to the shadow register are ignored.
// - Shadow plus separate two-bit latch double-buffer the duty value.
// - Pin clears when shadow and latch equal count extended by two bits.
// - Duty longer than period never clears the pin; output stays high.
// - Timer prescale factors are 1, 4 and 16.
module tpd_pwm_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic pwmOut,
    output logic pwmOutEnN
);
    tpd_pkg::tpd_state_s q;
    tpd_pkg::tpd_state_s d;
    tpd_pkg::tpd_phase_s phase;
    logic periodMatch;
    logic dutyMatch;
    logic pwmMode;
    logic timerRun;
    logic countWrite;
    logic ctlWrite;
    logic flagSet;
    logic accept;
    logic [7:0] addrIdx;
    logic [9:0] dutyFull;
    logic [7:0] wrData;

    // Reads a register from a state image; unmapped indices read as zero.
    function automatic logic [7:0] readReg(input logic [7:0] idx,
                                           input tpd_pkg::tpd_state_s s);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            tpd_pkg::IDX_INT_CTL: v = s.intCtl;
            tpd_pkg::IDX_IRQ_FLAGS: v = s.irqFlags & tpd_pkg::IRQ_MASK;
            tpd_pkg::IDX_COUNT: v = s.count;
            tpd_pkg::IDX_T2_CTL: v = s.t2Ctl & tpd_pkg::T2_CTL_MASK;
            tpd_pkg::IDX_DUTY_HIGH: v = s.dutyHigh;
            tpd_pkg::IDX_SHADOW: v = s.shadow;
            tpd_pkg::IDX_CC_CTL: v = s.ccCtl & tpd_pkg::CC_CTL_MASK;
            tpd_pkg::IDX_PORT_DIR: v = s.portDir;
            tpd_pkg::IDX_IRQ_EN: v = s.irqEn & tpd_pkg::IRQ_MASK;
            tpd_pkg::IDX_PERIOD: v = s.period;
            default: v = 8'h00;
        endcase
        readReg = v;
    endfunction

    assign pwmMode = (q.ccCtl[tpd_pkg::CC_MODE_LSB +: 2] == tpd_pkg::PWM_MODE);
    assign timerRun = q.t2Ctl[tpd_pkg::T2_RUN_BIT];
    assign dutyFull = {q.dutyHigh, q.ccCtl[tpd_pkg::CC_DUTY_LSB +: 2]};
    assign countWrite = ce && q.dataWrite && (q.dataIdx == tpd_pkg::IDX_COUNT);
    assign ctlWrite = ce && q.dataWrite && (q.dataIdx == tpd_pkg::IDX_CC_CTL);
    assign wrData = hwdata[7:0];
    assign accept = hsel && htrans[1] && hready;
    assign addrIdx = (haddr[31:10] == 22'h0) ? haddr[9:2] : tpd_pkg::IDX_NONE;
    assign flagSet = periodMatch && (q.postCnt == q.t2Ctl[tpd_pkg::T2_POST_LSB +: 4]);

    tpd_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .run(timerRun),
        .clear(countWrite),
        .sel(q.t2Ctl[1:0]),
        .phase(phase)
    );

    tpd_duty_match u_duty_match (
        .count(q.count),
        .period(q.period),
        .shadow(q.shadow),
        .latchLow(q.latchLow),
        .phase(phase),
        .periodMatch(periodMatch),
        .dutyMatch(dutyMatch)
    );

    always_comb begin
        d = q;
        // Timer count and postscaler.
        if (phase.tick) begin
            d.count = periodMatch ? 8'h00 : q.count + 8'h01;
        end
        if (periodMatch) begin
            d.postCnt = flagSet ? 4'h0 : q.postCnt + 4'h1;
        end
        // Double buffer: both halves of the duty value move together at the match.
        if (periodMatch) begin
            d.shadow = q.dutyHigh;
            d.latchLow = q.ccCtl[tpd_pkg::CC_DUTY_LSB +: 2];
            d.pinOut = (dutyFull != 10'h000);
        end else if (dutyMatch) begin
            d.pinOut = 1'b0;
        end
        if (!pwmMode) begin
            d.pinOut = 1'b0;
        end
        // Data phase of a write.
        if (q.dataWrite) begin
            unique case (q.dataIdx)
                tpd_pkg::IDX_INT_CTL: d.intCtl = wrData;
                tpd_pkg::IDX_IRQ_FLAGS: d.irqFlags = wrData & tpd_pkg::IRQ_MASK;
                tpd_pkg::IDX_COUNT: d.count = wrData;
                tpd_pkg::IDX_T2_CTL: d.t2Ctl = wrData & tpd_pkg::T2_CTL_MASK;
                tpd_pkg::IDX_DUTY_HIGH: d.dutyHigh = wrData;
                tpd_pkg::IDX_SHADOW: begin
                    if (!pwmMode) begin
                        d.shadow = wrData;
                    end
                end
                tpd_pkg::IDX_CC_CTL: d.ccCtl = wrData & tpd_pkg::CC_CTL_MASK;
                tpd_pkg::IDX_PORT_DIR: d.portDir = wrData;
                tpd_pkg::IDX_IRQ_EN: d.irqEn = wrData & tpd_pkg::IRQ_MASK;
                tpd_pkg::IDX_PERIOD: d.period = wrData;
                default: begin
                end
            endcase
        end
        // A timer match in the same cycle as a software clear keeps the flag set.
        if (flagSet) begin
            d.irqFlags[tpd_pkg::FLAG_TMR_BIT] = 1'b1;
        end
        // Address phase; read data is taken from the next-state image so that a
        // read right behind a write returns the written value.
        d.hreadyout = 1'b1;
        d.hresp = 1'b0;
        d.dataWrite = accept && hwrite;
        d.dataIdx = accept ? addrIdx : tpd_pkg::IDX_NONE;
        if (accept && !hwrite) begin
            d.hrdata = {24'h0, readReg(addrIdx, d)};
        end
        if (!ce) begin
            d = q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q.intCtl <= tpd_pkg::RST_INT_CTL;
            q.irqFlags <= tpd_pkg::RST_IRQ;
            q.irqEn <= tpd_pkg::RST_IRQ;
            q.count <= tpd_pkg::RST_COUNT;
            q.t2Ctl <= tpd_pkg::RST_T2_CTL;
            q.dutyHigh <= tpd_pkg::RST_DUTY;
            q.shadow <= tpd_pkg::RST_DUTY;
            q.ccCtl <= tpd_pkg::RST_CC_CTL;
            q.portDir <= tpd_pkg::RST_PORT_DIR;
            q.period <= tpd_pkg::RST_PERIOD;
            q.latchLow <= 2'h0;
            q.postCnt <= 4'h0;
            q.pinOut <= 1'b0;
            q.hreadyout <= 1'b1;
            q.hresp <= 1'b0;
            q.hrdata <= 32'h0;
            q.dataWrite <= 1'b0;
            q.dataIdx <= tpd_pkg::IDX_NONE;
        end else begin
            q <= d;
        end
    end

    assign hrdata = q.hrdata;
    assign hreadyout = q.hreadyout;
    assign hresp = q.hresp;
    assign pwmOut = q.pinOut;
    // Software clears the direction bit before starting the timer.
    assign pwmOutEnN = q.portDir[tpd_pkg::PIN_DIR_BIT];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_shadow_load: assert property (periodMatch |=> ({q.shadow, q.latchLow} == $past(dutyFull)))
        else $error("shadow did not take the duty value at period match");

    a_shadow_ro: assert property ((pwmMode && !periodMatch) |=> $stable({q.shadow, q.latchLow}))
        else $error("shadow changed between period matches in pulse mode");

    a_pin_set: assert property ((periodMatch && pwmMode && !ctlWrite)
        |=> (pwmOut == ($past(dutyFull) != 10'h000)))
        else $error("pin level wrong after period match");

    a_pin_clear: assert property ((dutyMatch && pwmMode && !ctlWrite) |=> !pwmOut)
        else $error("pin not cleared at duty match");

    a_over_period: assert property ((pwmMode && pwmOut && !periodMatch && !ctlWrite
        && ({q.shadow, q.latchLow} > {q.period, 2'b11})) |=> pwmOut)
        else $error("pin cleared although duty exceeds period");

    a_count_wrap: assert property ((periodMatch && !countWrite) |=> (q.count == 8'h00))
        else $error("count not cleared at period match");

    a_count_hold: assert property ((!timerRun && !countWrite) |=> $stable(q.count))
        else $error("count moved while the timer is stopped");

    // The pin is high for the three cycles after the match edge and low on the fourth.
    a_high_time: assert property ((phase.step && q.t2Ctl[1:0] == tpd_pkg::PRE_SEL_1
        && periodMatch && pwmMode && !ctlWrite && dutyFull == 10'h003 && q.period != 8'h00
        && q.t2Ctl[tpd_pkg::T2_RUN_BIT] && !q.dataWrite)
        ##1 (ce && !q.dataWrite) [*3] |-> pwmOut ##1 !pwmOut)
        else $error("high time at prescale one is not the duty value");

    a_flag_set: assert property (flagSet |=> q.irqFlags[tpd_pkg::FLAG_TMR_BIT])
        else $error("timer match flag lost");

endmodule // tpd_pwm_top
`default_nettype wire

// ### verilog/tpd_pkg.sv
// Package of the timer-based pulse-width unit: register indices, field layout,
// reset values and the state carriers shared by the unit and its helpers.
// Assumes a single clock domain and a word-per-register bus map.
package tpd_pkg;

    // Clock figures: one instruction cycle is four clock periods.
    localparam int TOSC_NS = 20;
    localparam int CLKS_PER_INSTR = 4;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_NONE = 8'h00;
    localparam logic [7:0] IDX_INT_CTL = 8'h0B;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_COUNT = 8'h11;
    localparam logic [7:0] IDX_T2_CTL = 8'h12;
    localparam logic [7:0] IDX_DUTY_HIGH = 8'h15;
    localparam logic [7:0] IDX_SHADOW = 8'h16;
    localparam logic [7:0] IDX_CC_CTL = 8'h17;
    localparam logic [7:0] IDX_PORT_DIR = 8'h86;
    localparam logic [7:0] IDX_IRQ_EN = 8'h8C;
    localparam logic [7:0] IDX_PERIOD = 8'h92;

    // Values after reset.
    localparam logic [7:0] RST_INT_CTL = 8'h00;
    localparam logic [7:0] RST_IRQ = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_T2_CTL = 8'h00;
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [7:0] RST_CC_CTL = 8'h00;
    localparam logic [7:0] RST_PORT_DIR = 8'hFF;
    localparam logic [7:0] RST_PERIOD = 8'hFF;

    // Field positions and implemented-bit masks.
    localparam int T2_RUN_BIT = 2;
    localparam int T2_POST_LSB = 3;
    localparam int CC_DUTY_LSB = 4;
    localparam int CC_MODE_LSB = 2;
    localparam int PIN_DIR_BIT = 3;
    localparam int FLAG_TMR_BIT = 1;
    localparam logic [7:0] T2_CTL_MASK = 8'h7F;
    localparam logic [7:0] CC_CTL_MASK = 8'h3F;
    localparam logic [7:0] IRQ_MASK = 8'hF7;
    localparam logic [1:0] PWM_MODE = 2'b11;

    // Prescale selections and the last prescaler count of each.
    localparam logic [1:0] PRE_SEL_1 = 2'b00;
    localparam logic [1:0] PRE_SEL_4 = 2'b01;
    localparam logic [3:0] PRE_LAST_1 = 4'h0;
    localparam logic [3:0] PRE_LAST_4 = 4'h3;
    localparam logic [3:0] PRE_LAST_16 = 4'hF;
    localparam logic [1:0] Q_LAST = 2'h3;

    typedef struct packed {
        logic step;
        logic tick;
        logic [1:0] extNext;
    } tpd_phase_s;

    typedef struct packed {
        logic [1:0] qPhase;
        logic [3:0] preCnt;
    } tpd_pre_state_s;

    typedef struct packed {
        logic [7:0] intCtl;
        logic [7:0] irqFlags;
        logic [7:0] irqEn;
        logic [7:0] count;
        logic [7:0] t2Ctl;
        logic [7:0] dutyHigh;
        logic [7:0] shadow;
        logic [7:0] ccCtl;
        logic [7:0] portDir;
        logic [7:0] period;
        logic [1:0] latchLow;
        logic [3:0] postCnt;
        logic pinOut;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        logic dataWrite;
        logic [7:0] dataIdx;
    } tpd_state_s;

endpackage

// ### verilog/tpd_prescaler.sv
// Quarter-phase counter and 1/4/16 prescaler that pace the period timer.
// Assumes run, sel and clear are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tpd_prescaler (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic run,
    input wire logic clear,
    input wire logic [1:0] sel,
    output tpd_pkg::tpd_phase_s phase
);
    tpd_pkg::tpd_pre_state_s q;
    tpd_pkg::tpd_pre_state_s d;
    logic [3:0] lastCnt;

    always_comb begin
        d = q;
        if (sel == tpd_pkg::PRE_SEL_1) begin
            lastCnt = tpd_pkg::PRE_LAST_1;
        end else if (sel == tpd_pkg::PRE_SEL_4) begin
            lastCnt = tpd_pkg::PRE_LAST_4;
        end else begin
            lastCnt = tpd_pkg::PRE_LAST_16;
        end
        if (run) begin
            d.qPhase = q.qPhase + 2'h1;
            if (q.qPhase == tpd_pkg::Q_LAST) begin
                d.preCnt = (q.preCnt == lastCnt) ? 4'h0 : q.preCnt + 4'h1;
            end
        end
        if (clear) begin
            d = '0;
        end
        // The two extension bits step once per oscillator period times the prescale.
        phase.tick = ce && run && !clear && (q.qPhase == tpd_pkg::Q_LAST) && (q.preCnt == lastCnt);
        if (sel == tpd_pkg::PRE_SEL_1) begin
            phase.step = ce && run && !clear;
            phase.extNext = d.qPhase;
        end else if (sel == tpd_pkg::PRE_SEL_4) begin
            phase.step = ce && run && !clear && (q.qPhase == tpd_pkg::Q_LAST);
            phase.extNext = d.preCnt[1:0];
        end else begin
            phase.step = ce && run && !clear && (q.qPhase == tpd_pkg::Q_LAST)
                && (q.preCnt[1:0] == 2'h3);
            phase.extNext = d.preCnt[3:2];
        end
        if (!ce) begin
            d = q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_tick_spacing: assert property (phase.tick |=> (!phase.tick) [*3])
        else $error("timer ticks closer than one instruction cycle");

endmodule // tpd_prescaler
`default_nettype wire

// ### verilog/tpd_duty_match.sv
// Period and duty comparators of the pulse-width unit.
// Assumes all inputs come from registers of the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module tpd_duty_match (
    input wire logic [7:0] count,
    input wire logic [7:0] period,
    input wire logic [7:0] shadow,
    input wire logic [1:0] latchLow,
    input wire tpd_pkg::tpd_phase_s phase,
    output logic periodMatch,
    output logic dutyMatch
);
    logic [9:0] fineNext;

    function automatic logic fineEq(input logic [9:0] a, input logic [9:0] b);
        fineEq = (a == b);
    endfunction

    always_comb begin
        periodMatch = phase.tick && (count == period);
        if (phase.tick) begin
            fineNext = {periodMatch ? 8'h00 : count + 8'h01, 2'b00};
        end else begin
            fineNext = {count, phase.extNext};
        end
        // The pin falls at the edge where the fine count reaches the duty value.
        dutyMatch = phase.step && !periodMatch && fineEq(fineNext, {shadow, latchLow});
    end

endmodule // tpd_duty_match
`default_nettype wire

// ### testbench/tpd_pin_load.sv
// Model of the load on the pulse output pin: resolves the pin and times its pulses.
// Assumes it runs on the unit's clk_sys and that the pin has a pull-down.
`timescale 1ns/1ps
`default_nettype none
module tpd_pin_load (
    input wire logic clk_sys,
    input wire logic pwmOut,
    input wire logic pwmOutEnN,
    output var int highCnt,
    output var int periodCnt,
    output var int nRise,
    output var int nFall
);
    logic pinLevel;
    logic prevQ;
    int hiRun;
    int perRun;
    // A released pin is pulled low by the load.
    assign pinLevel = pwmOutEnN ? 1'b0 : pwmOut;
    initial begin
        prevQ = 1'b0;
        hiRun = 0;
        perRun = 0;
        highCnt = 0;
        periodCnt = 0;
        nRise = 0;
        nFall = 0;
    end
    always @(posedge clk_sys) begin
        prevQ <= pinLevel;
        perRun <= perRun + 1;
        if (pinLevel) begin
            hiRun <= hiRun + 1;
        end
        if (pinLevel && !prevQ) begin
            periodCnt <= perRun;
            perRun <= 1;
            hiRun <= 1;
            nRise <= nRise + 1;
        end
        if (!pinLevel && prevQ) begin
            highCnt <= hiRun;
            nFall <= nFall + 1;
        end
    end
endmodule // tpd_pin_load
`default_nettype wire

// ### testbench/timer2_based_pwm_duty_unit_tb_top.sv
// Self-checking bench of the pulse-width unit, driven over AHB-Lite.
// Assumes tpd_pwm_top with zero wait states and the pin load model beside it.
`timescale 1ns/1ps
`default_nettype none
module timer2_based_pwm_duty_unit_tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pwmOut;
    logic pwmOutEnN;
    logic [31:0] rd;
    int highCnt, periodCnt, nRise, nFall;
    int nErrors = 0;
    int samplesChecked = 0;

    always #10 clk_sys = ~clk_sys;

    tpd_pwm_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pwmOut(pwmOut), .pwmOutEnN(pwmOutEnN));

    tpd_pin_load load_u (.clk_sys(clk_sys), .pwmOut(pwmOut), .pwmOutEnN(pwmOutEnN),
        .highCnt(highCnt), .periodCnt(periodCnt), .nRise(nRise), .nFall(nFall));

    task automatic conclude();
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samplesChecked++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic waitReady();
        int k;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (hreadyout !== 1'b1) begin
            check(32'h0, 32'h1, "bus ready timeout");
            conclude();
        end
    endtask

    task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        waitReady();
        rd = hrdata;
        check({31'h0, hresp}, 32'h0, "response code");
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask

    task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp, input string what);
        bus(idx, 1'b0, 8'h00);
        check(rd, {24'h0, exp}, what);
    endtask

    task automatic waitRises(input int n);
        int start;
        int k;
        start = nRise;
        k = 0;
        while (nRise < start + n && k < 4000) begin
            @(posedge clk_sys);
            k++;
        end
        if (nRise < start + n) begin
            check(32'h0, 32'h1, "pulse timeout");
            conclude();
        end
    endtask

    task automatic resetValues();
        logic [7:0] idx [11] = '{8'h0B, 8'h0C, 8'h11, 8'h12, 8'h15, 8'h16, 8'h17, 8'h86,
            8'h8C, 8'h92, 8'h00};
        logic [7:0] exp [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
            8'h00, 8'hFF, 8'h00};
        check({31'h0, pwmOut}, 32'h0, "pin level after reset");
        check({31'h0, pwmOutEnN}, 32'h1, "pin enable after reset");
        for (int i = 0; i < 11; i++) begin
            rdChk(idx[i], exp[i], "reset value");
        end
    endtask

    task automatic accessAndShadow();
        wr(8'h15, 8'hA5);
        rdChk(8'h15, 8'hA5, "duty high readback");
        wr(8'h16, 8'h5A);
        rdChk(8'h16, 8'h5A, "shadow outside pulse mode");
        wr(8'h17, 8'hFF);
        rdChk(8'h17, 8'h3F, "compare control readback");
        wr(8'h16, 8'h33);
        rdChk(8'h16, 8'h5A, "shadow write in pulse mode");
        rdChk(8'h16, 8'h5A, "shadow before any match");
        wr(8'h12, 8'hFB);
        rdChk(8'h12, 8'h7B, "timer control readback");
        wr(8'h00, 8'h77);
        rdChk(8'h00, 8'h00, "unmapped register");
    endtask

    // Duty {01,10} = 6 and period limit 3 give 6*pre high clocks in 16*pre.
    task automatic runPwm(input logic [1:0] sel, input int pre);
        wr(8'h12, 8'h00);
        wr(8'h11, 8'h00);
        wr(8'h92, 8'h03);
        wr(8'h15, 8'h01);
        wr(8'h17, 8'h2C);
        wr(8'h86, 8'hF7);
        // The direction register updates at the data-phase edge; look one edge later.
        @(posedge clk_sys);
        check({31'h0, pwmOutEnN}, 32'h0, "pin enable");
        wr(8'h12, {6'h01, sel});
        waitRises(3);
        check(highCnt, 6 * pre, "high time");
        check(periodCnt, 16 * pre, "period");
        rdChk(8'h16, 8'h01, "shadow after match");
    endtask

    // Duty {00,11} = 3 at prescale one with period limit 3: 3 high clocks in 16.
    task automatic shortPulse();
        wr(8'h12, 8'h00);
        wr(8'h11, 8'h00);
        wr(8'h15, 8'h00);
        wr(8'h17, 8'h3C);
        wr(8'h12, 8'h04);
        waitRises(3);
        check(highCnt, 3, "short high time");
        check(periodCnt, 16, "short period");
    endtask

    task automatic stopHolds();
        logic [7:0] held;
        wr(8'h12, 8'h00);
        bus(8'h11, 1'b0, 8'h00);
        held = rd[7:0];
        repeat (20) @(posedge clk_sys);
        rdChk(8'h11, held, "count while stopped");
    endtask

    task automatic dutyBeyondPeriod();
        int n;
        wr(8'h15, 8'h04);
        wr(8'h17, 8'h0C);
        wr(8'h12, 8'h04);
        repeat (40) @(posedge clk_sys);
        n = nFall;
        repeat (64) @(posedge clk_sys);
        check(nFall - n, 0, "falls with long duty");
        check({31'h0, pwmOut}, 32'h1, "pin with long duty");
    endtask

    task automatic dutyZero();
        int n;
        wr(8'h15, 8'h00);
        repeat (40) @(posedge clk_sys);
        n = nRise;
        repeat (64) @(posedge clk_sys);
        check(nRise - n, 0, "rises with zero duty");
        check({31'h0, pwmOut}, 32'h0, "pin with zero duty");
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        resetValues();
        accessAndShadow();
        runPwm(2'b00, 1);
        runPwm(2'b01, 4);
        runPwm(2'b10, 16);
        runPwm(2'b11, 16);
        shortPulse();
        stopHolds();
        dutyBeyondPeriod();
        dutyZero();
        conclude();
    end
endmodule // timer2_based_pwm_duty_unit_tb_top
`default_nettype wire
